// *** src/sio_params.svh ***
// Purpose: offsets, field positions, reset values and counts of the port
// Assumes: included by the package and by the design modules
// Notes:   definitions only
`ifndef SIO_PARAMS_SVH
`define SIO_PARAMS_SVH

// apb word offsets (byte addresses)
`define SIO_ADDR_W          12
`define SIO_CTRL_OFFSET     12'h000
`define SIO_STATUS_OFFSET   12'h004
`define SIO_TXDATA_OFFSET   12'h008
`define SIO_RXDATA_OFFSET   12'h00C

// serial_port_control field positions
`define SIO_CTRL_W          7
`define SIO_TM_BIT          6
`define SIO_SE_BIT          5
`define SIO_DL_BIT          4
`define SIO_TIE_BIT         3
`define SIO_RIE_BIT         2
`define SIO_TE_BIT          1
`define SIO_RE_BIT          0
`define SIO_CTRL_RESET      7'h00

// serial_port_status field positions and reset value
`define SIO_FLAG_W          4
`define SIO_UNDERRUN_BIT    3
`define SIO_OVERRUN_BIT     2
`define SIO_EMPTY_BIT       1
`define SIO_FULL_BIT        0
`define SIO_STATUS_RESET    16'h0002

// word lengths in serial clock periods
`define SIO_DATA_W          16
`define SIO_LEN_SHORT       5'h08
`define SIO_LEN_LONG        5'h10
`define SIO_CNT_W           5

// synchronised pin positions
`define SIO_PIN_W           5
`define SIO_PIN_TXCLK       0
`define SIO_PIN_TXFS        1
`define SIO_PIN_RXCLK       2
`define SIO_PIN_RXFS        3
`define SIO_PIN_RXD         4

`endif

// *** src/sio_pkg.sv ***
// Purpose: types shared by the serial port design
// Assumes: sio_params.svh holds every number
// Notes:   the register and sequencer state of the port is one packed struct
`include "sio_params.svh"

package sio_pkg;

	// complete register and sequencer state of the port
	typedef struct packed {
		logic [`SIO_CTRL_W-1:0] ctrl;
		logic [`SIO_FLAG_W-1:0] flags;
		logic [`SIO_FLAG_W-1:0] rd_seen;
		logic [`SIO_DATA_W-1:0] tx_data;
		logic [`SIO_DATA_W-1:0] rx_data;
		logic [`SIO_DATA_W-1:0] tx_shift;
		logic [`SIO_CNT_W-1:0]  tx_cnt;
		logic                   tx_active;
		logic                   tx_sync_out;
		logic [`SIO_DATA_W-1:0] rx_shift;
		logic [`SIO_CNT_W-1:0]  rx_cnt;
		logic                   rx_active;
		logic                   ack;
		logic [31:0]            prdata;
	} sio_state_t;

endpackage : sio_pkg

// *** src/pin_sync.sv ***
// Purpose: two-flop synchroniser with rising edge detect for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   the first stage feeds only the second stage
`include "sio_params.svh"

module pin_sync #(
	parameter int W = `SIO_PIN_W
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	// pins in
	input  wire logic [W-1:0] pins,
	// synchronised level and rising edge pulse
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} sync_state_t;

	sync_state_t s_reg;
	sync_state_t s_next;

	// shift the pins through meta, sync and the edge history
	always_comb begin
		s_next      = s_reg;
		s_next.meta = pins;
		s_next.sync = s_reg.meta;
		s_next.prev = s_reg.sync;
	end

	// frozen while ce is low, edges stay pending for later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// outputs from the second and third stages only
	assign level = s_reg.sync;
	assign rise  = s_reg.sync & ~s_reg.prev;

endmodule // pin_sync

// *** src/serial_port_status.sv ***
// Purpose: serial port flags, interrupt and dma requests, framing
// Assumes: apb3 slave with one wait state; serial pins are asynchronous
// Notes:   serial clocks are sampled by pclk, so they must be slow
//          a pin edge reaches the sequencers three pclk edges late
//          change mode, length and sync source only while disabled
//
// Behaviour
// - status resets to 0x0002, only transmit empty set.
// - status bits 15 to 4 read zero; software writes zero.
// - status flags clear by writing 0 after a read of 1; writing 1 is ignored.
// - word start while transmit empty is set raises underrun.
// - word received while receive full is set raises overrun.
// - underrun and overrun clear by read-1-then-write-0, and at reset.
// - transmit empty clears by read-1-write-0 or dma data write.
// - transmit empty sets on shift load, transmit disable, reset.
// - receive full clears on dma read, read-write-0, rx disable, reset.
// - receive full sets when a word moves into receive data.
// - four requests: overrun, underrun, receive full, transmit empty.
// - full and empty requests gated by enables; errors unmaskable.
// - receive full request follows the flag and may start dma reads.
// - transmit empty request follows the flag, may start dma writes.
// - error requests follow their flags and never start dma.
// - priority: overrun, underrun, receive full, transmit empty.
// - sync-every-word selects interval mode, else continuous mode.
// - continuous needs sync only for the first word; interval each.
// - sync source bit makes the port drive its own transmit sync.
// - length bit selects 8-bit low byte or 16-bit words.
// - transmit words go out msb first on serial clock rising edge.
//
// Chosen here: the address map and the APB register port.
`include "sio_params.svh"

module serial_port_status
	import sio_pkg::*;
(
	// clock, reset, enable
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   ce,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`SIO_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// dma engine side
	input  wire logic                   dma_tx_wr,
	input  wire logic [`SIO_DATA_W-1:0] dma_tx_data,
	input  wire logic                   dma_rx_rd,
	output logic      [`SIO_DATA_W-1:0] dma_rx_data,
	output logic                        dma_tx_req,
	output logic                        dma_rx_req,
	// requests to the irq controller
	output logic                        overrun_irq,
	output logic                        underrun_irq,
	output logic                        rx_full_irq,
	output logic                        tx_empty_irq,
	output logic                        irq_any,
	output logic      [1:0]             irq_top,
	// transmit pins
	input  wire logic                   tx_serial_clock,
	input  wire logic                   tx_frame_sync_in,
	output logic                        tx_frame_sync_out,
	output logic                        tx_frame_sync_oe,
	output logic                        tx_serial_out,
	output logic                        tx_serial_out_oe,
	// receive pins
	input  wire logic                   rx_serial_clock,
	input  wire logic                   rx_frame_sync,
	input  wire logic                   rx_serial_in
);

	sio_state_t s_reg;
	sio_state_t s_next;

	logic [`SIO_PIN_W-1:0] pin_level;
	logic [`SIO_PIN_W-1:0] pin_rise;

	// address decode, used only by the error answer; the read mux decodes on its own
	function automatic logic addr_hit(input logic [`SIO_ADDR_W-1:0] a);
		addr_hit = (a == `SIO_CTRL_OFFSET) || (a == `SIO_STATUS_OFFSET) ||
			(a == `SIO_TXDATA_OFFSET) || (a == `SIO_RXDATA_OFFSET);
	endfunction

	// read mux; narrow registers sit in the low bits
	function automatic logic [31:0] reg_read(
		input logic [`SIO_ADDR_W-1:0] a,
		input sio_state_t             st
	);
		reg_read = 32'h0000_0000;
		if (a == `SIO_CTRL_OFFSET) begin
			reg_read[`SIO_CTRL_W-1:0] = st.ctrl;
		end else if (a == `SIO_STATUS_OFFSET) begin
			reg_read[`SIO_FLAG_W-1:0] = st.flags;
		end else if (a == `SIO_TXDATA_OFFSET) begin
			reg_read[`SIO_DATA_W-1:0] = st.tx_data;
		end else if (a == `SIO_RXDATA_OFFSET) begin
			reg_read[`SIO_DATA_W-1:0] = st.rx_data;
		end
	endfunction

	// all serial pins cross into pclk here
	// packing order must follow the pin position constants
	pin_sync #(
		.W (`SIO_PIN_W)
	) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.pins    ({rx_serial_in, rx_frame_sync, rx_serial_clock,
			tx_frame_sync_in, tx_serial_clock}),
		.level   (pin_level),
		.rise    (pin_rise)
	);

	// bus events and helpers
	logic                   apb_done;
	logic                   apb_wr;
	logic                   apb_rd;
	logic                   ctrl_wr;
	logic                   stat_wr;
	logic                   stat_rd;
	// enable falls and serial clock edges
	logic                   te_fall;
	logic                   re_fall;
	logic                   tx_rise;
	logic                   rx_rise;
	// sequencer helpers
	logic                   tx_sync_hi;
	logic                   tx_load;
	logic                   rx_done;
	logic                   interval;
	logic [`SIO_CNT_W-1:0]  word_len;
	logic [`SIO_DATA_W-1:0] rx_new;
	// flag events of this cycle
	logic [`SIO_FLAG_W-1:0] flag_set;
	logic [`SIO_FLAG_W-1:0] flag_clr;

	// next state of the whole port, worked out once a cycle
	always_comb begin
		s_next     = s_reg;
		apb_done   = psel & penable & s_reg.ack;
		apb_wr     = apb_done & pwrite;
		apb_rd     = apb_done & ~pwrite;
		ctrl_wr    = apb_wr & (paddr == `SIO_CTRL_OFFSET);
		stat_wr    = apb_wr & (paddr == `SIO_STATUS_OFFSET);
		stat_rd    = apb_rd & (paddr == `SIO_STATUS_OFFSET);
		flag_set   = '0;
		flag_clr   = '0;
		tx_load    = 1'b0;
		rx_done    = 1'b0;
		rx_new     = s_reg.rx_shift;

		// one wait state: capture read data, answer next cycle
		s_next.ack = psel & penable & ~s_reg.ack;
		// read data is frozen in the wait state and cannot move
		if (psel & penable & ~s_reg.ack) begin
			s_next.prdata = reg_read(paddr, s_reg);
		end

		// control register write
		if (ctrl_wr) begin
			s_next.ctrl = pwdata[`SIO_CTRL_W-1:0];
		end
		// enable falls count in the cycle of the write itself
		te_fall = s_reg.ctrl[`SIO_TE_BIT] & ~s_next.ctrl[`SIO_TE_BIT];
		re_fall = s_reg.ctrl[`SIO_RE_BIT] & ~s_next.ctrl[`SIO_RE_BIT];

		// transmit data: cpu store keeps the flag, dma store clears it
		if (apb_wr & (paddr == `SIO_TXDATA_OFFSET)) begin
			s_next.tx_data = pwdata[`SIO_DATA_W-1:0];
		end
		if (dma_tx_wr) begin
			s_next.tx_data = dma_tx_data;
			flag_clr[`SIO_EMPTY_BIT] = 1'b1;
		end
		// a dma read of receive data empties the register
		if (dma_rx_rd) begin
			flag_clr[`SIO_FULL_BIT] = 1'b1;
		end

		// software clear: zero bit plus an earlier read of one
		if (stat_wr) begin
			flag_clr = flag_clr |
				(~pwdata[`SIO_FLAG_W-1:0] & s_reg.rd_seen);
			s_next.rd_seen = s_reg.rd_seen &
				pwdata[`SIO_FLAG_W-1:0];
		end
		// a bit written 1 keeps its record for a later clear
		if (stat_rd) begin
			s_next.rd_seen = s_reg.rd_seen | s_reg.flags;
		end

		// mode and length shared by both directions
		interval = s_reg.ctrl[`SIO_SE_BIT];
		word_len = s_reg.ctrl[`SIO_DL_BIT] ?
			`SIO_LEN_LONG : `SIO_LEN_SHORT;

		// transmit sequencer on rising edges of the serial clock
		tx_rise    = pin_rise[`SIO_PIN_TXCLK] & s_reg.ctrl[`SIO_TE_BIT];
		tx_sync_hi = s_reg.ctrl[`SIO_TM_BIT] ? s_reg.tx_sync_out :
			pin_level[`SIO_PIN_TXFS];
		if (tx_rise) begin
			// own sync: one clock period whenever idle with data waiting
			s_next.tx_sync_out = ~s_reg.tx_active & ~s_reg.tx_sync_out &
				~s_reg.flags[`SIO_EMPTY_BIT] &
				s_reg.ctrl[`SIO_TM_BIT];
			if (s_reg.tx_active && s_reg.tx_cnt != 5'h01) begin
				// mid word: next bit onto the line
				s_next.tx_shift = {s_reg.tx_shift[14:0], 1'b0};
				s_next.tx_cnt   = s_reg.tx_cnt - 5'h01;
			end else if (s_reg.tx_active && !interval) begin
				// continuous: the next word follows the last bit
				tx_load = 1'b1;
			end else if (tx_sync_hi) begin
				// first word, or interval mode: a sync starts it
				tx_load = 1'b1;
			end else begin
				// nothing starts: the line idles until a sync
				s_next.tx_active = 1'b0;
				s_next.tx_cnt    = '0;
			end
		end
		if (tx_load) begin
			// an 8-bit word is left aligned so the msb leads
			s_next.tx_shift  = s_reg.ctrl[`SIO_DL_BIT] ? s_reg.tx_data :
				{s_reg.tx_data[7:0], 8'h00};
			s_next.tx_cnt    = word_len;
			s_next.tx_active = 1'b1;
			// the data register is free again once the word moves
			flag_set[`SIO_EMPTY_BIT] = 1'b1;
			// a load with nothing new written repeats stale data
			flag_set[`SIO_UNDERRUN_BIT] =
				s_reg.flags[`SIO_EMPTY_BIT];
		end
		if (te_fall) begin
			// transmitter off: drop the word, free the register
			s_next.tx_active   = 1'b0;
			s_next.tx_cnt      = '0;
			s_next.tx_sync_out = 1'b0;
			flag_set[`SIO_EMPTY_BIT] = 1'b1;
		end

		// receive sequencer: sync edge arms, then one bit per edge
		rx_rise = pin_rise[`SIO_PIN_RXCLK] & s_reg.ctrl[`SIO_RE_BIT];
		if (rx_rise) begin
			if (s_reg.rx_active) begin
				// armed: one bit per edge, msb first
				rx_new = {s_reg.rx_shift[14:0], pin_level[`SIO_PIN_RXD]};
				s_next.rx_shift = rx_new;
				s_next.rx_cnt   = s_reg.rx_cnt - 5'h01;
				if (s_reg.rx_cnt == 5'h01) begin
					rx_done = 1'b1;
					// continuous mode runs on without another sync
					s_next.rx_active = ~interval;
					s_next.rx_cnt    = interval ? 5'h00 : word_len;
				end
			end else if (pin_level[`SIO_PIN_RXFS]) begin
				// the sync edge only arms; bits start on the next edge
				s_next.rx_active = 1'b1;
				s_next.rx_cnt    = word_len;
			end
		end
		if (rx_done) begin
			s_next.rx_data = s_reg.ctrl[`SIO_DL_BIT] ? rx_new :
				{8'h00, rx_new[7:0]};
			flag_set[`SIO_FULL_BIT] = 1'b1;
			// an unread word is overwritten; overrun keeps the evidence
			flag_set[`SIO_OVERRUN_BIT] =
				s_reg.flags[`SIO_FULL_BIT];
		end
		if (re_fall) begin
			// receiver off: a half word is lost
			s_next.rx_active = 1'b0;
			s_next.rx_cnt    = '0;
			flag_clr[`SIO_FULL_BIT] = 1'b1;
		end

		// set beats clear so a coincident event survives
		s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;

		// a record dies with its flag, so a stale read clears no new word
		s_next.rd_seen = s_next.rd_seen & s_next.flags;
	end

	// single state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg         <= '0;
			s_reg.ctrl    <= `SIO_CTRL_RESET;
			// the status value is wider than the flags it holds
			s_reg.flags   <=
				`SIO_FLAG_W'(`SIO_STATUS_RESET);
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// apb answer
	assign prdata  = s_reg.prdata;
	assign pready  = s_reg.ack;
	// unmapped offsets answer with an error rather than hang
	assign pslverr = s_reg.ack & ~addr_hit(paddr);

	// request lines: errors cannot be masked
	assign overrun_irq  = s_reg.flags[`SIO_OVERRUN_BIT];
	assign underrun_irq = s_reg.flags[`SIO_UNDERRUN_BIT];
	assign rx_full_irq  = s_reg.flags[`SIO_FULL_BIT] &
		s_reg.ctrl[`SIO_RIE_BIT];
	assign tx_empty_irq = s_reg.flags[`SIO_EMPTY_BIT] &
		s_reg.ctrl[`SIO_TIE_BIT];

	// dma only on the data requests, never on errors
	assign dma_rx_req  = rx_full_irq;
	assign dma_tx_req  = tx_empty_irq;
	assign dma_rx_data = s_reg.rx_data;

	// fixed priority code of the highest pending request
	assign irq_any = overrun_irq | underrun_irq | rx_full_irq |
		tx_empty_irq;
	// code 3 also when nothing pends, so qualify it with irq_any
	always_comb begin
		if (overrun_irq) begin
			irq_top = 2'h0;
		end else if (underrun_irq) begin
			irq_top = 2'h1;
		end else if (rx_full_irq) begin
			irq_top = 2'h2;
		end else begin
			irq_top = 2'h3;
		end
	end

	// pins float while the transmitter is off
	// data idles at whatever bit was shifted last
	assign tx_serial_out     = s_reg.tx_shift[`SIO_DATA_W-1];
	assign tx_serial_out_oe  = s_reg.ctrl[`SIO_TE_BIT];
	assign tx_frame_sync_out = s_reg.tx_sync_out;
	assign tx_frame_sync_oe  = s_reg.ctrl[`SIO_TE_BIT] &
		s_reg.ctrl[`SIO_TM_BIT];

endmodule // serial_port_status

// *** tb/serial_port_status_assertions.sv ***
// Purpose: port-level checks of serial_port_status
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound into every instance of the design
module serial_port_status_chk (
	// clock and reset
	input logic       pclk,
	input logic       presetn,
	// apb
	input logic       psel,
	input logic       penable,
	input logic       pwrite,
	input logic       pready,
	input logic       pslverr,
	// dma
	input logic       dma_tx_wr,
	input logic       dma_rx_rd,
	input logic       dma_tx_req,
	input logic       dma_rx_req,
	// requests
	input logic       overrun_irq,
	input logic       underrun_irq,
	input logic       rx_full_irq,
	input logic       tx_empty_irq,
	input logic       irq_any,
	input logic [1:0] irq_top,
	// transmit sync pin
	input logic       tx_frame_sync_out,
	input logic       tx_frame_sync_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_dma_req_follow: assert property (
		dma_tx_req == tx_empty_irq && dma_rx_req == rx_full_irq)
		else $error("dma request differs from its irq");
	chk_any_req_or: assert property (
		irq_any == (overrun_irq | underrun_irq | rx_full_irq | tx_empty_irq))
		else $error("irq_any is not the or of the requests");
	chk_top_priority: assert property (
		irq_top == (overrun_irq ? 2'h0 : underrun_irq ? 2'h1 :
			rx_full_irq ? 2'h2 : 2'h3))
		else $error("irq_top breaks the fixed priority");
	chk_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// requests only fall through a completed apb write or, for full and empty, a dma strobe
	chk_over_clear: assert property (
		$fell(overrun_irq) |-> $past(pwrite && pready))
		else $error("overrun request fell without a write");
	chk_full_clear: assert property (
		$fell(rx_full_irq) |-> $past(pwrite && pready || dma_rx_rd))
		else $error("rx full request fell without a cause");
	chk_empty_clear: assert property (
		$fell(tx_empty_irq) |-> $past(pwrite && pready || dma_tx_wr))
		else $error("tx empty request fell without a cause");
	chk_sync_driven: assert property (
		tx_frame_sync_out |-> tx_frame_sync_oe)
		else $error("own sync raised while the sync pin is not driven");
endmodule // serial_port_status_chk

bind serial_port_status serial_port_status_chk i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.dma_tx_wr(dma_tx_wr), .dma_rx_rd(dma_rx_rd), .dma_tx_req(dma_tx_req),
	.dma_rx_req(dma_rx_req), .overrun_irq(overrun_irq),
	.underrun_irq(underrun_irq), .rx_full_irq(rx_full_irq),
	.tx_empty_irq(tx_empty_irq), .irq_any(irq_any), .irq_top(irq_top),
	.tx_frame_sync_out(tx_frame_sync_out),
	.tx_frame_sync_oe(tx_frame_sync_oe));

// *** tb/codec_model.sv ***
// Purpose: far-side serial codec sharing one bit clock for both ways
// Assumes: bit clock of 125 ns, still between frames
// Notes:   sync is sent only with the first edge of a frame
module codec_model (
	// link pins
	output logic sclk,
	output logic fs,
	output logic sd,
	input  logic td
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] got;

	initial begin
		sclk = 1'b0;
		fs   = 1'b0;
		sd   = 1'b0;
		got  = 16'h0000;
	end

	// one frame: sync edge, then msb-first bits; later edges carry noise
	task automatic frame(input int edges, input int n, input logic [15:0] w);
		fs = 1'b1;
		#62.5;
		for (int k = 0; k < edges; k++) begin
			sclk = 1'b1;
			#62.5;
			sclk = 1'b0;
			fs   = 1'b0;
			if (k < n) got[n-1-k] = td;
			sd = (k < n) ? w[n-1-k] : ~sd;
			#62.5;
		end
		sd = ~sd; // released line shows no stale bit
	endtask
endmodule // codec_model

// *** tb/serial_port_status_tb_top.sv ***
// Purpose: self-checking bench for serial_port_status
// Assumes: apb answers after a wait state; codec model drives the link
// Notes:   expected read results are queued and compared by a monitor
`include "sio_params.svh"

module serial_port_status_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        dma_tx_wr, dma_rx_rd, dma_tx_req, dma_rx_req;
	logic [15:0] dma_tx_data, dma_rx_data, w, rxw, m;
	logic        overrun_irq, underrun_irq, rx_full_irq, tx_empty_irq;
	logic        irq_any, fs_out, fs_oe, fs_wire, txd, txd_oe, sclk, fs, sd;
	logic [1:0]  irq_top;
	logic [32:0] expq[$];
	int          n_mismatch, checks_done;

	serial_port_status i_serial_port_status (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data),
		.dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data),
		.dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req),
		.overrun_irq(overrun_irq), .underrun_irq(underrun_irq),
		.rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq),
		.irq_any(irq_any), .irq_top(irq_top), .tx_serial_clock(sclk),
		.tx_frame_sync_in(fs_wire), .tx_frame_sync_out(fs_out),
		.tx_frame_sync_oe(fs_oe), .tx_serial_out(txd),
		.tx_serial_out_oe(txd_oe), .rx_serial_clock(sclk),
		.rx_frame_sync(fs), .rx_serial_in(sd));
	codec_model i_codec_model (.sclk(sclk), .fs(fs), .sd(sd), .td(txd));
	// sync pin level from both drivers
	assign fs_wire = fs_oe ? fs_out : fs;

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// apb master; a read notes its expected {pslverr, prdata}
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] exp);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		if (!wr) expq.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check(1'b0, 1'b1);
			close_out();
		end
		{psel, penable} <= 2'b00;
	endtask

	// one-cycle dma strobe, then let the flag settle
	task automatic dma(input logic wr, input logic [15:0] d);
		@(posedge pclk);
		{dma_tx_wr, dma_rx_rd, dma_tx_data} <= {wr, !wr, d};
		@(posedge pclk);
		{dma_tx_wr, dma_rx_rd} <= 2'b00;
		@(posedge pclk);
		#1;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// completed reads are judged against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check({pslverr, prdata}, expq.pop_front());
		end
	end

	// cuts a hang short, far beyond the eleven or so microseconds of traffic
	initial begin
		#200us;
		n_mismatch++;
		close_out();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{dma_tx_wr, dma_rx_rd, dma_tx_data, presetn} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(80456));
		apb(1, `SIO_STATUS_OFFSET, 32'h0, 0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'h2);
		apb(0, 12'h010, 0, {1'b1, 32'h0});
		apb(1, `SIO_STATUS_OFFSET, 32'h0000000F, 0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'h2);
		apb(1, `SIO_STATUS_OFFSET, 32'h0, 0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'h0);
		apb(1, `SIO_CTRL_OFFSET, 32'h7F, 0);
		apb(0, `SIO_CTRL_OFFSET, 0, 33'h7F);
		apb(1, `SIO_CTRL_OFFSET, 32'h0, 0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'h2);
		check(tx_empty_irq, 1'b0);
		check({fs_oe, txd_oe}, 2'b00);
		apb(1, `SIO_CTRL_OFFSET, 32'h08, 0);
		wait_clk(2);
		check({tx_empty_irq, dma_tx_req}, 2'b11);
		dma(1'b1, 16'($urandom));
		check({tx_empty_irq, dma_tx_req}, 2'b00);
		// interval frames, 16-bit then 8-bit words
		for (int dl = 1; dl >= 0; dl--) begin
			m = dl ? 16'hFFFF : 16'h00FF;
			w = 16'($urandom);
			rxw = 16'($urandom);
			apb(1, `SIO_CTRL_OFFSET, 32'h0, 0);
			apb(1, `SIO_CTRL_OFFSET, dl ? 32'h3F : 32'h2F, 0);
			dma(1'b1, w);
			i_codec_model.frame(dl ? 17 : 9, dl ? 16 : 8, rxw);
			wait_clk(8);
			check(i_codec_model.got & m, w & m);
			check(dma_rx_data, rxw & m);
			check({rx_full_irq, tx_empty_irq, underrun_irq}, 3'b110);
			apb(0, `SIO_STATUS_OFFSET, 0, 33'h3);
			apb(0, `SIO_RXDATA_OFFSET, 0, {17'h0, rxw & m});
			dma(1'b0, 16'h0000);
			check({rx_full_irq, dma_rx_req}, 2'b00);
		end
		// own transmit sync: first edge raises it, the word follows
		apb(1, `SIO_CTRL_OFFSET, 32'h0, 0);
		apb(1, `SIO_CTRL_OFFSET, 32'h62, 0);
		w = 16'($urandom);
		dma(1'b1, w);
		check({fs_oe, txd_oe}, 2'b11);
		i_codec_model.frame(10, 9, 16'h0000);
		wait_clk(8);
		check(i_codec_model.got[7:0], w[7:0]);
		check(fs_out, 1'b0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'h2);
		// continuous, nothing refilled: both error flags
		apb(1, `SIO_CTRL_OFFSET, 32'h0, 0);
		apb(1, `SIO_CTRL_OFFSET, 32'h1F, 0);
		i_codec_model.frame(34, 16, 16'($urandom));
		wait_clk(8);
		check({overrun_irq, underrun_irq}, 2'b11);
		check(irq_top, 2'h0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'hF);
		apb(1, `SIO_STATUS_OFFSET, 32'hB, 0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'hB);
		wait_clk(1);
		check(irq_top, 2'h1);
		apb(1, `SIO_STATUS_OFFSET, 32'h0, 0);
		apb(0, `SIO_STATUS_OFFSET, 0, 33'h0);
		wait_clk(1);
		check(irq_any, 1'b0);
		close_out();
	end
endmodule // serial_port_status_tb_top
